//--- shared/cdcr_params.svh
// constants for the decoder configuration register bank
`ifndef CDCR_PARAMS_SVH
`define CDCR_PARAMS_SVH

// command that carries one register write
`define CDCR_CMD_WRITE_DEC 8'hd1

// register numbers
`define CDCR_ADDR_PLL 4'h8
`define CDCR_ADDR_DAO 4'ha
`define CDCR_ADDR_SPEED 4'hb
`define CDCR_ADDR_PINC 4'hc
`define CDCR_ADDR_PIND 4'hd
`define CDCR_ADDR_FEAT 4'he
`define CDCR_ADDR_SUBC 4'hf

// power-on values
`define CDCR_RST_PLL 4'h9
`define CDCR_RST_DAO 4'h2
`define CDCR_RST_SPEED 4'h0
`define CDCR_RST_PINC 4'h2
`define CDCR_RST_PIND 4'hf
`define CDCR_RST_FEAT 4'h4
`define CDCR_RST_SUBC 4'h0

// field positions
`define CDCR_DAO_ACC_LO 0
`define CDCR_DAO_CONCEAL 1
`define CDCR_DAO_ACC_HI 2
`define CDCR_DAO_FLAGS 3
`define CDCR_SPD_XTAL 2
`define CDCR_SPD_DOUBLE 3
`define CDCR_PINC_EXT_OT 0
`define CDCR_PINC_SPLIT 1
`define CDCR_PINC_PIN3 2
`define CDCR_FEAT_BRAKE 0
`define CDCR_FEAT_LTD 1
`define CDCR_FEAT_AUDIO 2
`define CDCR_FEAT_QUAD 3
`define CDCR_SUBC_FMT 3

// field codes
`define CDCR_RUN_STOP 2'h0
`define CDCR_RUN_PAUSE 2'h2
`define CDCR_RUN_OPER 2'h3
`define CDCR_PIN_SIGNAL 2'h1
`define CDCR_PIN_LOW 2'h2
`define CDCR_MOTOR4_CODE 4'h0
`define CDCR_SUBC_ON 3'h4
`define CDCR_N_1X 3'h1
`define CDCR_N_2X 3'h2
`define CDCR_N_4X 3'h4

`endif

//--- shared/cdcr_pkg.sv
// types shared by the decoder configuration register bank
package cdcr_pkg;
   // disc speed, gray coded along 1x -> 2x -> 4x
   typedef enum logic [1:0] {
      CDCR_SPEED_1X = 2'b00,
      CDCR_SPEED_2X = 2'b01,
      CDCR_SPEED_4X = 2'b11
   } cdcr_speed_t;
   // operating state, gray coded along stop -> pause -> run
   typedef enum logic [1:0] {
      CDCR_OP_STOP = 2'b00,
      CDCR_OP_PAUSE = 2'b01,
      CDCR_OP_RUN = 2'b11
   } cdcr_opstate_t;
endpackage : cdcr_pkg

//--- src/cdcr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cdcr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : cdcr_sync

//--- src/cdcr_nibble_reg.sv
// one 4-bit write-only configuration register with its own address decode
`timescale 1ns/100ps
module cdcr_nibble_reg #(
   parameter logic [3:0] ADDR = 4'h0,
   parameter logic [3:0] RESET = 4'h0
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_wr_en,
   input wire logic [3:0] i_wr_addr,
   input wire logic [3:0] i_wr_data,
   output logic [3:0] o_value
);
   wire hit = i_wr_en && (i_wr_addr == ADDR);

   // holds the power-on value until a write lands here
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_value <= RESET;
      end else if (hit) begin
         o_value <= i_wr_data;
      end
   end

   property p_write_lands;
      @(posedge i_clock) disable iff (!i_rst_b)
      hit |=> o_value == $past(i_wr_data);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("register write not stored");
endmodule : cdcr_nibble_reg

//--- src/cdcr_config_regs.sv
// decoder configuration register bank and the pin functions it steers
`timescale 1ns/100ps
`include "cdcr_params.svh"
module cdcr_config_regs (
   input wire logic i_clock,
   input wire logic i_rst_b,
   // command interface from the servo command decoder
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   input wire logic [7:0] i_cmd_data,
   input wire logic i_dec_if_enable,
   // internal signals routed to the pins
   input wire logic i_dao_serial,
   input wire logic i_offtrack_internal,
   input wire logic i_kill_left,
   input wire logic i_kill_right,
   input wire logic i_kill_mono,
   input wire logic i_qw_subcode,
   input wire logic i_deemph,
   input wire logic i_motor_line_a,
   input wire logic i_motor_line_b,
   // pins
   input wire logic i_aux_pin_one,
   output logic o_digital_audio_out,
   output logic o_kill,
   output logic o_aux_pin_three,
   output logic o_aux_pin_four,
   output logic o_aux_pin_five,
   // decoded configuration
   output logic o_aux_pin_one_status,
   output logic o_offtrack,
   output logic o_dao_after_conceal,
   output logic o_dao_flags_on,
   output logic [1:0] o_dao_accuracy,
   output logic o_dao_off,
   output logic o_xtal_16m,
   output cdcr_pkg::cdcr_speed_t o_speed_mode,
   output cdcr_pkg::cdcr_opstate_t o_op_state,
   output logic o_motor_four_line,
   output logic o_deemph_bypass,
   output logic o_audio_features,
   output logic o_lock_to_disc,
   output logic o_brake_6pct,
   output logic o_subcode_on,
   output logic o_subcode_3wire,
   output logic [1:0] o_pll_loop_bw,
   output logic [1:0] o_pll_int_bw,
   output logic [2:0] o_pll_bw_scale_n
);
   // ***************************************************************
   // command acceptance and register storage
   // ***************************************************************
   logic [3:0] pll_loop_bandwidth;
   logic [3:0] digital_audio_output_config;
   logic [3:0] speed_control;
   logic [3:0] offtrack_kill_pin_config;
   logic [3:0] aux_pin_function_config;
   logic [3:0] feature_control;
   logic [3:0] subcode_port_config;
   logic pin_one_sync;

   // power-on register images, so the output flops reset to the decoded fields
   localparam logic [3:0] RST_PLL = `CDCR_RST_PLL;
   localparam logic [3:0] RST_DAO = `CDCR_RST_DAO;
   localparam logic [3:0] RST_PIND = `CDCR_RST_PIND;
   localparam logic [3:0] RST_FEAT = `CDCR_RST_FEAT;

   // writes outside the enabled decoder interface are dropped silently
   wire wr_en = i_cmd_valid && i_dec_if_enable && (i_cmd_code == `CDCR_CMD_WRITE_DEC);
   wire [3:0] wr_addr = i_cmd_data[7:4]; // register number in high nibble
   wire [3:0] wr_data = i_cmd_data[3:0];

   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_PLL), .RESET(`CDCR_RST_PLL)) u_reg_pll (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(pll_loop_bandwidth)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_DAO), .RESET(`CDCR_RST_DAO)) u_reg_dao (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(digital_audio_output_config)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_SPEED), .RESET(`CDCR_RST_SPEED)) u_reg_speed (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(speed_control)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_PINC), .RESET(`CDCR_RST_PINC)) u_reg_pinc (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(offtrack_kill_pin_config)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_PIND), .RESET(`CDCR_RST_PIND)) u_reg_pind (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(aux_pin_function_config)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_FEAT), .RESET(`CDCR_RST_FEAT)) u_reg_feat (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(feature_control)
   );
   cdcr_nibble_reg #(.ADDR(`CDCR_ADDR_SUBC), .RESET(`CDCR_RST_SUBC)) u_reg_subc (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_value(subcode_port_config)
   );

   // aux pin one arrives from outside the clock domain
   cdcr_sync #(.WIDTH(1)) u_sync_pin_one (
      .i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_async(i_aux_pin_one), .o_sync(pin_one_sync)
   );

   // ***************************************************************
   // field decode
   // ***************************************************************
   // digital audio output: accuracy code 11 switches it off
   wire dao_acc_hi = digital_audio_output_config[`CDCR_DAO_ACC_HI];
   wire dao_acc_lo = digital_audio_output_config[`CDCR_DAO_ACC_LO];
   wire dao_off_d = dao_acc_hi && dao_acc_lo;
   wire dao_out_d = dao_off_d ? 1'b0 : i_dao_serial;

   // speed: the double-speed bit wins over the quad bit, combination 11 is unused
   wire spd_double = speed_control[`CDCR_SPD_DOUBLE];
   wire spd_quad = feature_control[`CDCR_FEAT_QUAD];
   cdcr_pkg::cdcr_speed_t speed_d;
   assign speed_d = spd_double ? cdcr_pkg::CDCR_SPEED_2X :
      (spd_quad ? cdcr_pkg::CDCR_SPEED_4X : cdcr_pkg::CDCR_SPEED_1X);

   // the bandwidth factor n tracks the disc speed so the loop scales with it
   wire [2:0] scale_n_d = spd_double ? `CDCR_N_2X :
      (spd_quad ? `CDCR_N_4X : `CDCR_N_1X);

   // operating state; unused code 01 is treated as stop for safety
   wire [1:0] run_code = speed_control[1:0];
   cdcr_pkg::cdcr_opstate_t op_d;
   assign op_d = (run_code == `CDCR_RUN_OPER) ? cdcr_pkg::CDCR_OP_RUN :
      ((run_code == `CDCR_RUN_PAUSE) ? cdcr_pkg::CDCR_OP_PAUSE : cdcr_pkg::CDCR_OP_STOP);

   // off-track source and kill pin routing
   wire ext_ot = offtrack_kill_pin_config[`CDCR_PINC_EXT_OT];
   wire offtrack_d = ext_ot ? pin_one_sync : i_offtrack_internal;
   wire kill_split = !offtrack_kill_pin_config[`CDCR_PINC_SPLIT];
   wire kill_d = kill_split ? i_kill_left : i_kill_mono;
   wire pin3_d = kill_split ? i_kill_right : offtrack_kill_pin_config[`CDCR_PINC_PIN3];

   // versatile pins four and five; code 00 in one half is unused and drives 1, but 00 in both halves selects the four-line motor
   wire motor4_d = (aux_pin_function_config == `CDCR_MOTOR4_CODE);
   wire [1:0] pin4_code = aux_pin_function_config[1:0];
   wire [1:0] pin5_code = aux_pin_function_config[3:2];
   wire pin4_sel = (pin4_code == `CDCR_PIN_SIGNAL) ? i_qw_subcode :
      (pin4_code != `CDCR_PIN_LOW);
   wire pin5_sel = (pin5_code == `CDCR_PIN_SIGNAL) ? i_deemph :
      (pin5_code != `CDCR_PIN_LOW);
   wire pin4_d = motor4_d ? i_motor_line_a : pin4_sel;
   wire pin5_d = motor4_d ? i_motor_line_b : pin5_sel;
   wire bypass_d = !motor4_d && (pin5_code == `CDCR_PIN_SIGNAL);

   // subcode port: only x100 turns it on, every other low code is off
   wire subc_on_d = (subcode_port_config[2:0] == `CDCR_SUBC_ON);

   // ***************************************************************
   // registered outputs
   // ***************************************************************
   // every output leaves through a flop, costing one cycle after a write
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_digital_audio_out <= 1'b0;
         o_dao_off <= 1'b0;
         o_dao_accuracy <= 2'h0;
         o_dao_after_conceal <= RST_DAO[`CDCR_DAO_CONCEAL];
         o_dao_flags_on <= 1'b0;
         o_xtal_16m <= 1'b0;
         o_speed_mode <= cdcr_pkg::CDCR_SPEED_1X;
         o_pll_bw_scale_n <= `CDCR_N_1X;
         o_op_state <= cdcr_pkg::CDCR_OP_STOP;
      end else begin
         o_digital_audio_out <= dao_out_d;
         o_dao_off <= dao_off_d;
         o_dao_accuracy <= {dao_acc_hi, dao_acc_lo};
         o_dao_after_conceal <= digital_audio_output_config[`CDCR_DAO_CONCEAL];
         o_dao_flags_on <= digital_audio_output_config[`CDCR_DAO_FLAGS];
         o_xtal_16m <= speed_control[`CDCR_SPD_XTAL];
         o_speed_mode <= speed_d;
         o_pll_bw_scale_n <= scale_n_d;
         o_op_state <= op_d;
      end
   end

   // pin routing flops; reset values match the power-on register fields
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_aux_pin_one_status <= 1'b0;
         o_offtrack <= 1'b0;
         o_kill <= 1'b0;
         o_aux_pin_three <= 1'b0;
         o_aux_pin_four <= (RST_PIND[1:0] != `CDCR_PIN_LOW);
         o_aux_pin_five <= (RST_PIND[3:2] != `CDCR_PIN_LOW);
         o_motor_four_line <= 1'b0;
         o_deemph_bypass <= 1'b0;
      end else begin
         o_aux_pin_one_status <= pin_one_sync;
         o_offtrack <= offtrack_d;
         o_kill <= kill_d;
         o_aux_pin_three <= pin3_d;
         o_aux_pin_four <= pin4_d;
         o_aux_pin_five <= pin5_d;
         o_motor_four_line <= motor4_d;
         o_deemph_bypass <= bypass_d;
      end
   end

   // feature, subcode and loop filter fields
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_audio_features <= RST_FEAT[`CDCR_FEAT_AUDIO];
         o_lock_to_disc <= 1'b0;
         o_brake_6pct <= 1'b0;
         o_subcode_on <= 1'b0;
         o_subcode_3wire <= 1'b0;
         o_pll_loop_bw <= RST_PLL[1:0];
         o_pll_int_bw <= RST_PLL[3:2];
      end else begin
         o_audio_features <= feature_control[`CDCR_FEAT_AUDIO];
         o_lock_to_disc <= feature_control[`CDCR_FEAT_LTD];
         o_brake_6pct <= feature_control[`CDCR_FEAT_BRAKE];
         o_subcode_on <= subc_on_d;
         o_subcode_3wire <= subcode_port_config[`CDCR_SUBC_FMT];
         o_pll_loop_bw <= pll_loop_bandwidth[1:0];
         o_pll_int_bw <= pll_loop_bandwidth[3:2];
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_dao_write;
      @(posedge i_clock) disable iff (!i_rst_b)
      // a second write one cycle later is excluded, though it would reach the outputs only one cycle after this check
      (wr_en && wr_addr == `CDCR_ADDR_DAO) ##1 !(wr_en && wr_addr == `CDCR_ADDR_DAO) |=>
         (o_dao_after_conceal == $past(i_cmd_data[1], 2)) &&
         (o_dao_flags_on == $past(i_cmd_data[3], 2));
   endproperty
   a_dao_write: assert property (p_dao_write)
      else $error("digital audio config write not reflected");

   property p_dao_off_low;
      @(posedge i_clock) disable iff (!i_rst_b)
      (dao_acc_hi && dao_acc_lo) |=> (o_digital_audio_out == 1'b0) && o_dao_off;
   endproperty
   a_dao_off_low: assert property (p_dao_off_low)
      else $error("digital audio output not held low when off");

   property p_ignored_when_disabled;
      @(posedge i_clock) disable iff (!i_rst_b)
      (!i_dec_if_enable) |=> $stable(speed_control) && $stable(feature_control)
         && $stable(digital_audio_output_config);
   endproperty
   a_ignored_when_disabled: assert property (p_ignored_when_disabled)
      else $error("register changed with decoder interface disabled");

   property p_speed_quad;
      @(posedge i_clock) disable iff (!i_rst_b)
      (!spd_double && spd_quad) |=>
         (o_speed_mode == cdcr_pkg::CDCR_SPEED_4X) && (o_pll_bw_scale_n == `CDCR_N_4X);
   endproperty
   a_speed_quad: assert property (p_speed_quad)
      else $error("four times speed not selected");

   property p_scale_double;
      @(posedge i_clock) disable iff (!i_rst_b)
      spd_double |=> (o_pll_bw_scale_n == `CDCR_N_2X);
   endproperty
   a_scale_double: assert property (p_scale_double)
      else $error("bandwidth factor not two at double speed");

   property p_pause;
      @(posedge i_clock) disable iff (!i_rst_b)
      (run_code == `CDCR_RUN_PAUSE) |=> (o_op_state == cdcr_pkg::CDCR_OP_PAUSE);
   endproperty
   a_pause: assert property (p_pause)
      else $error("pause standby not entered");

   property p_kill_split;
      @(posedge i_clock) disable iff (!i_rst_b)
      kill_split |=> (o_kill == $past(i_kill_left)) && (o_aux_pin_three == $past(i_kill_right));
   endproperty
   a_kill_split: assert property (p_kill_split)
      else $error("split kill routing wrong");

   property p_motor_four;
      @(posedge i_clock) disable iff (!i_rst_b)
      (aux_pin_function_config == `CDCR_MOTOR4_CODE) |=>
         (o_aux_pin_four == $past(i_motor_line_a)) && (o_aux_pin_five == $past(i_motor_line_b));
   endproperty
   a_motor_four: assert property (p_motor_four)
      else $error("four-line motor not on pins four and five");

   property p_deemph;
      @(posedge i_clock) disable iff (!i_rst_b)
      (!motor4_d && pin5_code == `CDCR_PIN_SIGNAL) |=>
         o_deemph_bypass && (o_aux_pin_five == $past(i_deemph));
   endproperty
   a_deemph: assert property (p_deemph)
      else $error("de-emphasis not routed to pin five");

   property p_offtrack_ext;
      @(posedge i_clock) disable iff (!i_rst_b)
      ext_ot |=> (o_offtrack == $past(pin_one_sync));
   endproperty
   a_offtrack_ext: assert property (p_offtrack_ext)
      else $error("external off-track not taken from pin one");

   property p_subcode_on;
      @(posedge i_clock) disable iff (!i_rst_b)
      (subcode_port_config[2:0] == `CDCR_SUBC_ON) |=> o_subcode_on;
   endproperty
   a_subcode_on: assert property (p_subcode_on)
      else $error("subcode interface not on");
endmodule : cdcr_config_regs

//--- test/cdcr_mcu_model.sv
// microcontroller model that issues decoder register write commands
`timescale 1ns/100ps
module cdcr_mcu_model (
   input wire logic i_clock,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_code,
   output logic [7:0] o_cmd_data
);
   // bus idles with no command at time zero
   initial begin
      o_cmd_valid = 1'h0;
      o_cmd_code = 8'h00;
      o_cmd_data = 8'h00;
   end

   // one command byte per edge; calls back to back give one write per cycle
   task send(input logic [7:0] code, input logic [3:0] num, input logic [3:0] val);
      @(posedge i_clock);
      o_cmd_valid <= 1'h1;
      o_cmd_code <= code;
      o_cmd_data <= {num, val};
   endtask : send

   // released lines show the inverse of the last value, never a stale copy
   task release_bus();
      @(posedge i_clock);
      o_cmd_valid <= 1'h0;
      o_cmd_code <= ~o_cmd_code;
      o_cmd_data <= ~o_cmd_data;
   endtask : release_bus
endmodule : cdcr_mcu_model

//--- test/cdcr_config_regs_tb_top.sv
// self-checking testbench for the decoder configuration register bank
`timescale 1ns/100ps
`include "cdcr_params.svh"
module cdcr_config_regs_tb_top;
   // ***************************************************************
   // stimulus and bookkeeping
   // ***************************************************************
   logic i_clock = 1'h0;
   logic i_rst_b = 1'h0;
   logic en = 1'h1;
   logic [9:0] s = 10'h000;
   logic cv;
   logic [7:0] cc;
   logic [7:0] cd;
   logic [3:0] v;
   logic [9:0] pt;
   logic [3:0] regs [7] = '{4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
   int error_cnt = 0;
   int n_tests = 0;

   // free running 40 MHz clock
   always #12.5 i_clock = ~i_clock;

   cdcr_mcu_model mcu (.i_clock(i_clock), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_data(cd));

   // every routed source comes from the pattern s, so no input is tied
   cdcr_config_regs dut (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_valid(cv), .i_cmd_code(cc),
      .i_cmd_data(cd), .i_dec_if_enable(en), .i_dao_serial(s[0]),
      .i_offtrack_internal(s[1]), .i_kill_left(s[2]), .i_kill_right(s[3]),
      .i_kill_mono(s[4]), .i_qw_subcode(s[5]), .i_deemph(s[6]),
      .i_motor_line_a(s[7]), .i_motor_line_b(s[8]), .i_aux_pin_one(s[9]),
      .o_digital_audio_out(), .o_kill(), .o_aux_pin_three(), .o_aux_pin_four(),
      .o_aux_pin_five(), .o_aux_pin_one_status(), .o_offtrack(), .o_dao_after_conceal(),
      .o_dao_flags_on(), .o_dao_accuracy(), .o_dao_off(), .o_xtal_16m(),
      .o_speed_mode(), .o_op_state(), .o_motor_four_line(), .o_deemph_bypass(),
      .o_audio_features(), .o_lock_to_disc(), .o_brake_6pct(), .o_subcode_on(),
      .o_subcode_3wire(), .o_pll_loop_bw(), .o_pll_int_bw(), .o_pll_bw_scale_n()
   );

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task tally_and_finish();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // three edges cover the decode delay and the two-flop pin one path
   task settle(input logic [9:0] p);
      mcu.release_bus();
      s <= p;
      repeat (3) @(posedge i_clock);
      #1;
   endtask : settle

   task rst_chk();
      chk({dut.o_dao_after_conceal, dut.o_dao_flags_on, dut.o_dao_accuracy, dut.o_dao_off,
           dut.o_xtal_16m, dut.o_speed_mode, dut.o_op_state, dut.o_motor_four_line,
           dut.o_deemph_bypass, dut.o_audio_features, dut.o_lock_to_disc, dut.o_brake_6pct,
           dut.o_subcode_on, dut.o_subcode_3wire, dut.o_pll_loop_bw, dut.o_pll_int_bw,
           dut.o_pll_bw_scale_n, dut.o_kill, dut.o_aux_pin_three, dut.o_aux_pin_four,
           dut.o_aux_pin_five, dut.o_digital_audio_out, dut.o_offtrack,
           dut.o_aux_pin_one_status}, {24'h800831, 7'h18});
   endtask : rst_chk

   // expected outputs of register number a after value v, sources p, quad bit ph
   task chk_reg(input logic [3:0] a, input logic [3:0] v, input logic [9:0] p,
                input logic ph);
      logic z;
      z = (v == 4'h0);
      case (a)
         4'h8: chk({dut.o_pll_loop_bw, dut.o_pll_int_bw}, {v[1:0], v[3:2]});
         4'ha: chk({dut.o_dao_after_conceal, dut.o_dao_flags_on, dut.o_dao_accuracy,
                    dut.o_dao_off, dut.o_digital_audio_out}, {v[1], v[3], v[2], v[0],
                    v[2] & v[0], p[0] & ~(v[2] & v[0])});
         4'hb: chk({dut.o_xtal_16m, dut.o_op_state, dut.o_speed_mode, dut.o_pll_bw_scale_n},
                   {v[2], (v[1:0] == 2'h3) ? 2'h3 : (v[1:0] == 2'h2) ? 2'h1 : 2'h0,
                    v[3] ? 2'h1 : (ph ? 2'h3 : 2'h0),
                    v[3] ? 3'h2 : (ph ? 3'h4 : 3'h1)});
         4'hc: chk({dut.o_offtrack, dut.o_aux_pin_one_status, dut.o_kill,
                    dut.o_aux_pin_three}, {v[0] ? p[9] : p[1], p[9],
                    v[1] ? p[4] : p[2], v[1] ? v[2] : p[3]});
         4'hd: chk({dut.o_motor_four_line, dut.o_deemph_bypass, dut.o_aux_pin_four,
                    dut.o_aux_pin_five}, {z, !z && v[3:2] == 2'h1,
                    z ? p[7] : (v[1:0] == 2'h1) ? p[5] : (v[1:0] != 2'h2),
                    z ? p[8] : (v[3:2] == 2'h1) ? p[6] : (v[3:2] != 2'h2)});
         4'he: chk({dut.o_audio_features, dut.o_lock_to_disc, dut.o_brake_6pct,
                    dut.o_speed_mode}, {v[2:0], 1'h0, v[3]});
         default: chk({dut.o_subcode_on, dut.o_subcode_3wire},
                      {v[2:0] == 3'h4, v[3]});
      endcase
   endtask : chk_reg

   // ***************************************************************
   // test sequence
   // ***************************************************************
   initial begin
      repeat (2) @(posedge i_clock);
      #1;
      rst_chk();
      @(posedge i_clock);
      i_rst_b <= 1'h1;
      // every value of every register, with two source patterns
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            pt = {v[0], ~v, ~v[0], v} ^ {10{p[0]}};
            foreach (regs[k]) begin
               // speed needs a fresh quad bit, sent back to back with the speed write
               if (regs[k] == 4'hb) mcu.send(`CDCR_CMD_WRITE_DEC, 4'he, {p[0], 3'h4});
               mcu.send(`CDCR_CMD_WRITE_DEC, regs[k], v);
               settle(pt);
               chk_reg(regs[k], v, pt, p[0]);
            end
         end
      end
      // refused writes: interface disabled, wrong code, numbers outside the bank
      @(posedge i_clock);
      en <= 1'h0;
      mcu.send(`CDCR_CMD_WRITE_DEC, 4'ha, 4'h0);
      settle(pt);
      chk({dut.o_dao_after_conceal, dut.o_dao_flags_on, dut.o_dao_accuracy,
           dut.o_dao_off}, 5'h1f);
      @(posedge i_clock);
      en <= 1'h1;
      mcu.send(8'hd0, 4'ha, 4'h0);
      mcu.send(`CDCR_CMD_WRITE_DEC, 4'h9, 4'h0);
      mcu.send(`CDCR_CMD_WRITE_DEC, 4'h2, 4'h0);
      mcu.send(`CDCR_CMD_WRITE_DEC, 4'h0, 4'h0);
      settle(pt);
      chk({dut.o_dao_after_conceal, dut.o_dao_flags_on, dut.o_dao_accuracy, dut.o_dao_off,
           dut.o_pll_loop_bw, dut.o_pll_int_bw}, 9'h1ff);
      // second reset in mid-run brings every field back
      @(posedge i_clock);
      i_rst_b <= 1'h0;
      @(posedge i_clock);
      #1;
      rst_chk();
      // release again: the first write after it must land normally
      @(posedge i_clock);
      i_rst_b <= 1'h1;
      mcu.send(`CDCR_CMD_WRITE_DEC, 4'ha, 4'h9);
      settle(pt);
      chk_reg(4'ha, 4'h9, pt, 1'h0);
      tally_and_finish();
   end

   // watchdog, well beyond the roughly 1200 cycles the sequence needs
   initial begin
      repeat (5000) @(posedge i_clock);
      error_cnt++;
      tally_and_finish();
   end
endmodule : cdcr_config_regs_tb_top
